/* hdl/dpb_host.sv */
// Host controller driving the parallel double-buffered DAC port from APB orders
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module dpb_host
  import dpb_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input dpb_pkg::dpb_apb_req_t apb_i,
  output dpb_pkg::dpb_apb_rsp_t apb_o,
  input wire logic [dpb_pkg::DATA_W-1:0] dac_code_pins_i,
  input wire logic [dpb_pkg::SPAN_W-1:0] range_code_pins_i,
  output dpb_pkg::dpb_pins_t pins_o
);
  import dpb_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_SAMPLE
  } dpb_state_t;

  dpb_state_t state_q;
  dpb_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [31:0] ctrl;
  logic [31:0] data;
  logic go;
  logic busy;
  logic done;
  logic [31:0] rdat;
  dpb_op_t op_q;
  logic sel_q;
  logic buf_q;
  logic fix_q;
  logic [DATA_W-1:0] code_q;
  logic [SPAN_W-1:0] rng_q;
  logic [DATA_W-1:0] code_s;
  logic [SPAN_W-1:0] rng_s;
  logic [31:0] rdat_q;
  logic wr_n_q;
  logic upd_q;
  logic rd_q;
  logic drive_q;
  logic cnt_done;
  logic op_sel;
  logic [31:0] ctrl_now;
  dpb_op_t op_cur;
  logic buf_cur;

  dpb_apb_regs u_regs (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .apb_i(apb_i),
    .apb_o(apb_o),
    .busy_i(busy),
    .done_i(done),
    .rdat_i(rdat),
    .ctrl_o(ctrl),
    .data_o(data),
    .go_o(go)
  );

  dpb_sync #(.W(DATA_W)) u_sync_code (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i(dac_code_pins_i),
    .q_o(code_s)
  );

  dpb_sync #(.W(SPAN_W)) u_sync_rng (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i(range_code_pins_i),
    .q_o(rng_s)
  );

  assign busy = (state_q != ST_IDLE);
  assign cnt_done = (cnt_q == 4'h0);
  assign done = (state_q == ST_SAMPLE);
  assign rdat = rdat_q;
  // Go lands with the control write itself, so its fields come from the bus word
  assign ctrl_now = go ? apb_i.pwdata : ctrl;
  assign op_cur = go ? dpb_op_t'(ctrl_now[CTRL_OP_LSB +: 2]) : op_q;
  assign buf_cur = go ? ctrl_now[CTRL_BUF_BIT] : buf_q;
  // In fixed-range mode the select stays low whatever software asked
  assign op_sel = ctrl_now[CTRL_SEL_BIT] & ~ctrl_now[CTRL_FIX_BIT];

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (!cnt_done) begin
      cnt_d = cnt_q - 4'h1;
    end
    case (state_q)
      ST_IDLE: begin
        if (go) begin
          state_d = ST_SETUP;
          cnt_d = SETUP_CNT;
        end
      end
      ST_SETUP: begin
        if (cnt_done) begin
          state_d = ST_STROBE;
          // Counter spans load plus one cycles
          cnt_d = STROBE_CNT - 4'h1;
        end
      end
      ST_STROBE: begin
        if (cnt_done) begin
          state_d = ST_HOLD;
          cnt_d = SETUP_CNT;
        end
      end
      ST_HOLD: begin
        if (cnt_done) begin
          state_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Latch the order at start so pins stay stable through the cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      op_q <= OP_NONE;
      sel_q <= 1'b0;
      buf_q <= 1'b0;
      fix_q <= 1'b0;
      code_q <= '0;
      rng_q <= SPAN_0_5;
    end else if (go) begin
      op_q <= op_cur;
      sel_q <= op_sel;
      buf_q <= buf_cur;
      fix_q <= ctrl_now[CTRL_FIX_BIT];
      code_q <= data[DATA_W-1:0];
      rng_q <= data[DATA_SPAN_LSB +: SPAN_W];
    end
  end

  // Strobe generation; write strobe rises while data still driven
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_n_q <= 1'b1;
      upd_q <= 1'b0;
      rd_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      wr_n_q <= ~((state_d == ST_STROBE) & (op_cur == OP_WRITE));
      // Update pulses only with read low
      // Buffer select drops before read does, else the device sees an update
      upd_q <= ((state_d == ST_STROBE) & (op_cur == OP_UPDATE)) |
               (((state_d == ST_SETUP) | (state_d == ST_STROBE)) &
                (op_cur == OP_READ) & buf_cur);
      rd_q <= (state_d != ST_IDLE) & (state_d != ST_SAMPLE) & (op_cur == OP_READ);
      drive_q <= (state_d != ST_IDLE) & (state_d != ST_SAMPLE) & (op_cur == OP_WRITE);
    end
  end

  // Read data sampled from synchronised pins before read falls
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0;
    end else if ((state_q == ST_HOLD) & cnt_done & (op_q == OP_READ)) begin
      rdat_q <= sel_q ? {29'h0, rng_s} : {14'h0, code_s};
    end
  end

  // Host never writes while read is high, so strobes never overlap
  assign pins_o.code_o = code_q;
  assign pins_o.code_oe_n = {DATA_W{~(drive_q & ~sel_q)}};
  assign pins_o.rng_o = rng_q;
  // Span pins stay released in fixed mode; jumpers set the range
  assign pins_o.rng_oe_n = {SPAN_W{~(drive_q & sel_q & ~fix_q)}};
  assign pins_o.sel_span = sel_q;
  assign pins_o.wr_n = wr_n_q;
  assign pins_o.xfer_buf = upd_q;
  assign pins_o.rd = rd_q;
  assign pins_o.fixed = fix_q;

  property p_no_wr_in_read;
    @(posedge sys_clk_i) disable iff (rst_i) rd_q |-> wr_n_q;
  endproperty
  a_no_wr_in_read: assert property (p_no_wr_in_read) else $error("write during read");

  property p_upd_not_write;
    @(posedge sys_clk_i) disable iff (rst_i) upd_q & ~rd_q |-> wr_n_q & (op_q == OP_UPDATE);
  endproperty
  a_upd_not_write: assert property (p_upd_not_write) else $error("bad update");

  property p_wr_drives;
    @(posedge sys_clk_i) disable iff (rst_i) !wr_n_q |-> drive_q & $stable(code_q);
  endproperty
  a_wr_drives: assert property (p_wr_drives) else $error("write without data");

  property p_wr_len;
    @(posedge sys_clk_i) disable iff (rst_i) $fell(wr_n_q) |-> !wr_n_q [*2] ##1 wr_n_q & drive_q;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe width");

  property p_fix_sel;
    @(posedge sys_clk_i) disable iff (rst_i) fix_q |-> !sel_q;
  endproperty
  a_fix_sel: assert property (p_fix_sel) else $error("select high in fixed mode");

  property p_fix_rng;
    @(posedge sys_clk_i) disable iff (rst_i) fix_q |-> &pins_o.rng_oe_n;
  endproperty
  a_fix_rng: assert property (p_fix_rng) else $error("span driven in fixed mode");

  property p_rd_release;
    @(posedge sys_clk_i) disable iff (rst_i) rd_q |-> &pins_o.code_oe_n & &pins_o.rng_oe_n;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("drive during read");

  property p_sel_group;
    @(posedge sys_clk_i) disable iff (rst_i) drive_q & sel_q |-> &pins_o.code_oe_n;
  endproperty
  a_sel_group: assert property (p_sel_group) else $error("wrong pin group");

  property p_done_time;
    @(posedge sys_clk_i) disable iff (rst_i) go |-> ##[6:10] done;
  endproperty
  a_done_time: assert property (p_done_time) else $error("operation late");

  // Pin sequencing checks
  property p_upd_len;
    @(posedge sys_clk_i) disable iff (rst_i) $rose(upd_q) & !rd_q |-> upd_q [*2] ##1 !upd_q;
  endproperty
  a_upd_len: assert property (p_upd_len) else $error("update pulse width");

  property p_buf_drop;
    @(posedge sys_clk_i) disable iff (rst_i) $fell(rd_q) |-> !upd_q & !$past(upd_q);
  endproperty
  a_buf_drop: assert property (p_buf_drop) else $error("update high as read ends");

  property p_sel_stable;
    @(posedge sys_clk_i) disable iff (rst_i)
      busy & $past(busy) |-> $stable(sel_q) & $stable(code_q) & $stable(rng_q);
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("order moved mid operation");

  property p_wr_setup;
    @(posedge sys_clk_i) disable iff (rst_i) $fell(wr_n_q) |-> $past(drive_q);
  endproperty
  a_wr_setup: assert property (p_wr_setup) else $error("no data setup before write");

  property p_rd_len;
    @(posedge sys_clk_i) disable iff (rst_i) $rose(rd_q) |-> rd_q [*6] ##1 !rd_q;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read line width");

  property p_no_mix;
    @(posedge sys_clk_i) disable iff (rst_i) !wr_n_q |-> !upd_q;
  endproperty
  a_no_mix: assert property (p_no_mix) else $error("write and update together");

  // Data must outlast the write strobe's rising edge
  property p_drive_rel;
    @(posedge sys_clk_i) disable iff (rst_i) $fell(drive_q) |-> wr_n_q & $past(wr_n_q);
  endproperty
  a_drive_rel: assert property (p_drive_rel) else $error("data released too early");

  property p_idle_quiet;
    @(posedge sys_clk_i) disable iff (rst_i)
      !busy & $past(!busy) |-> wr_n_q & !rd_q & !upd_q & !drive_q;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("strobe while idle");

  property p_go_busy;
    @(posedge sys_clk_i) disable iff (rst_i) go |=> busy & (state_q == ST_SETUP);
  endproperty
  a_go_busy: assert property (p_go_busy) else $error("start not taken");
endmodule

/* hdl/dpb_pkg.sv */
// Package: shared types, register map and timing for the parallel DAC host controller
package dpb_pkg;
  localparam int DATA_W = 18;
  localparam int SPAN_W = 3;
  localparam int ADDR_W = 12;

  // Software register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_DATA = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_STAT = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_RDAT = 12'h00c;

  // Control register fields (write with go set while idle starts an operation) and the data register's span field
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_SEL_BIT = 3;
  localparam int CTRL_BUF_BIT = 4;
  localparam int CTRL_FIX_BIT = 5;
  localparam int DATA_SPAN_LSB = 20;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  // Strobe timing in ns at 20 MHz
  localparam int CLK_NS = 50;
  localparam int STROBE_NS = 100;
  localparam int SETUP_NS = 50;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC);

  // Range codes
  localparam logic [2:0] SPAN_0_5 = 3'h0;

  typedef enum logic [1:0] {
    OP_WRITE,
    OP_UPDATE,
    OP_READ,
    OP_NONE
  } dpb_op_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } dpb_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dpb_apb_rsp_t;

  typedef struct packed {
    logic [DATA_W-1:0] code_o;
    logic [DATA_W-1:0] code_oe_n;
    logic [SPAN_W-1:0] rng_o;
    logic [SPAN_W-1:0] rng_oe_n;
    logic sel_span;
    logic wr_n;
    logic xfer_buf;
    logic rd;
    logic fixed;
  } dpb_pins_t;
endpackage

/* hdl/dpb_sync.sv */
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module dpb_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

/* hdl/dpb_apb_regs.sv */
// APB slave holding the controller's own control, data and status registers
`timescale 1ns/1ps
module dpb_apb_regs
  import dpb_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input dpb_pkg::dpb_apb_req_t apb_i,
  output dpb_pkg::dpb_apb_rsp_t apb_o,
  input wire logic busy_i,
  input wire logic done_i,
  input wire logic [31:0] rdat_i,
  output logic [31:0] ctrl_o,
  output logic [31:0] data_o,
  output logic go_o
);
  import dpb_pkg::*;

  logic [31:0] ctrl_q;
  logic [31:0] data_q;
  logic [31:0] rdat_q;
  logic done_q;
  logic [31:0] rd_mux;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic hit;

  assign acc = apb_i.psel & apb_i.penable;
  assign wr_acc = acc & apb_i.pwrite;
  assign rd_acc = acc & ~apb_i.pwrite;
  assign hit = (apb_i.paddr == OFS_CTRL) | (apb_i.paddr == OFS_DATA) |
               (apb_i.paddr == OFS_STAT) | (apb_i.paddr == OFS_RDAT);
  assign rd_mux = (apb_i.paddr == OFS_CTRL) ? ctrl_q :
                  (apb_i.paddr == OFS_DATA) ? data_q :
                  (apb_i.paddr == OFS_STAT) ? {30'h0, done_q, busy_i} :
                  (apb_i.paddr == OFS_RDAT) ? rdat_q : 32'h0;

  // Zero-wait slave; unmapped addresses answer with pslverr
  assign apb_o.pready = 1'b1;
  assign apb_o.pslverr = acc & ~hit;
  assign apb_o.prdata = rd_acc ? rd_mux : 32'h0;
  // A start request while busy is dropped
  assign go_o = wr_acc & (apb_i.paddr == OFS_CTRL) & apb_i.pwdata[CTRL_GO_BIT] & ~busy_i;
  assign ctrl_o = ctrl_q;
  assign data_o = data_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      data_q <= DATA_RST;
    end else if (wr_acc & ~busy_i) begin
      if (apb_i.paddr == OFS_CTRL) ctrl_q <= apb_i.pwdata;
      if (apb_i.paddr == OFS_DATA) data_q <= apb_i.pwdata;
    end
  end

  // Done is sticky; a new completion wins over the clear by read
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      if (done_i) begin
        done_q <= 1'b1;
        rdat_q <= rdat_i;
      end else if (rd_acc & (apb_i.paddr == OFS_STAT)) begin
        done_q <= 1'b0;
      end
    end
  end
endmodule

/* verification/dpb_dev_model.sv */
// Behavioural model of the double-buffered parallel DAC port
`timescale 1ns/1ps
module dpb_dev_model
  import dpb_pkg::*;
(
  input dpb_pkg::dpb_pins_t pins_i,
  output logic [dpb_pkg::DATA_W-1:0] code_o,
  output logic [dpb_pkg::SPAN_W-1:0] rng_o
);
  import dpb_pkg::*;
  logic [DATA_W-1:0] din_q = '0;
  logic [DATA_W-1:0] ddac_q = '0;
  logic [SPAN_W-1:0] sin_q = '0;
  logic [SPAN_W-1:0] sdac_q = '0;
  logic [DATA_W-1:0] code_last_q = '0;
  logic [SPAN_W-1:0] rng_last_q = '0;
  logic armed_q = 1'b0;
  wire rd_data = pins_i.rd & ~pins_i.sel_span;
  wire rd_span = pins_i.rd & pins_i.sel_span & ~pins_i.fixed;
  wire code_drv = rd_data | ~&pins_i.code_oe_n;
  wire rng_drv = rd_span | ~&pins_i.rng_oe_n;
  wire [DATA_W-1:0] code_val = rd_data ? (pins_i.xfer_buf ? ddac_q : din_q) : pins_i.code_o;
  wire [SPAN_W-1:0] rng_val = rd_span ? (pins_i.xfer_buf ? sdac_q : sin_q) : pins_i.rng_o;
  wire [SPAN_W-1:0] range_now = pins_i.fixed ? rng_o : sdac_q;
  // Released bus shows the inverse, no pull resistors
  assign code_o = code_drv ? code_val : ~code_last_q;
  assign rng_o = rng_drv ? rng_val : ~rng_last_q;
  always @* begin
    if (code_drv) code_last_q = code_val;
    if (rng_drv) rng_last_q = rng_val;
  end
  always @(posedge pins_i.wr_n) begin
    if (!pins_i.rd) begin
      if (pins_i.sel_span) sin_q <= rng_o;
      else din_q <= code_o;
    end
  end
  // Read line is judged after the edge, so an update line rising with read high does not count as update
  always @(posedge pins_i.xfer_buf) begin
    #1 armed_q = ~pins_i.rd;
  end
  always @(posedge pins_i.rd) armed_q = 1'b0;
  // Update line still high as read drops counts as an update
  always @(negedge pins_i.rd) begin
    if (pins_i.xfer_buf) armed_q = 1'b1;
  end
  always @(negedge pins_i.xfer_buf) begin
    if (armed_q) begin
      ddac_q <= din_q;
      sdac_q <= sin_q;
    end
  end
endmodule

/* verification/dpb_host_tb.sv */
// Self-checking testbench for the parallel DAC host controller
`timescale 1ns/1ps
module dpb_host_tb;
  import dpb_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_i = 1'b1;
  dpb_apb_req_t apb_req = '0;
  dpb_apb_rsp_t apb_rsp;
  dpb_pins_t pins;
  logic [DATA_W-1:0] code_w;
  logic [SPAN_W-1:0] rng_w;
  logic [31:0] rd_v;
  logic err_v;
  logic saw_fixed = 1'b0;
  logic fixed_bad = 1'b0;
  int fail_count = 0;
  int checks = 0;

  always #25 sys_clk = ~sys_clk;

  dpb_host i_dut (.sys_clk_i(sys_clk), .rst_i(rst_i), .apb_i(apb_req), .apb_o(apb_rsp),
    .dac_code_pins_i(code_w), .range_code_pins_i(rng_w), .pins_o(pins));
  dpb_dev_model i_dev (.pins_i(pins), .code_o(code_w), .rng_o(rng_w));

  always @(posedge sys_clk) begin
    if (pins.fixed === 1'b1) begin
      saw_fixed <= 1'b1;
      if (pins.sel_span !== 1'b0 || pins.rng_oe_n !== 3'h7) fixed_bad <= 1'b1;
    end
  end

  task results;
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= addr;
    apb_req.pwdata <= wd;
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    rd_v = apb_rsp.prdata;
    err_v = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (n >= 20) begin
      chk(0, 1, "bus answer timeout");
      results();
    end
  endtask

  task wait_done;
    int n;
    logic seen;
    seen = 1'b0;
    for (n = 0; n < 40; n++) begin
      apb(1'b0, OFS_STAT, 32'h0);
      if (rd_v[1] === 1'b1) seen = 1'b1;
      if (seen && rd_v[0] === 1'b0) break;
    end
    if (n >= 40) begin
      chk(0, 1, "operation timeout");
      results();
    end
  endtask

  task run_op(input dpb_op_t op, input logic sel, input logic bsel, input logic fix,
              input logic [31:0] data);
    apb(1'b1, OFS_DATA, data);
    apb(1'b1, OFS_CTRL, 32'h1 | (32'(op) << CTRL_OP_LSB) | (32'(sel) << CTRL_SEL_BIT)
        | (32'(bsel) << CTRL_BUF_BIT) | (32'(fix) << CTRL_FIX_BIT));
    wait_done();
  endtask

  task t_reset;
    chk(32'(pins.wr_n), 32'h1, "write strobe idle");
    chk(32'(pins.rd), 32'h0, "read line idle");
    chk(32'(pins.xfer_buf), 32'h0, "update line idle");
    chk(32'(pins.code_oe_n), 32'h3ffff, "data pins released");
    apb(1'b0, OFS_DATA, 32'h0);
    chk(rd_v, DATA_RST, "data register reset value");
    apb(1'b0, 12'hffc, 32'h0);
    chk(32'(err_v), 32'h1, "unmapped access error");
  endtask

  task t_write;
    run_op(OP_WRITE, 1'b0, 1'b0, 1'b0, 32'h0002_a5c3);
    chk(32'(i_dev.din_q), 32'h2a5c3, "data input register");
    chk(32'(i_dev.ddac_q), 32'h0, "dac register untouched by write");
    for (int s = 0; s < 6; s++) begin
      run_op(OP_WRITE, 1'b1, 1'b0, 1'b0, (32'(s) << DATA_SPAN_LSB) | 32'h3ffff);
      chk(32'(i_dev.sin_q), 32'(s), "span input register");
    end
    chk(32'(i_dev.din_q), 32'h2a5c3, "data kept on span write");
  endtask

  task t_update;
    run_op(OP_UPDATE, 1'b1, 1'b0, 1'b0, 32'h0);
    chk(32'(i_dev.ddac_q), 32'h2a5c3, "data dac register");
    chk(32'(i_dev.sdac_q), 32'h5, "span dac register");
    chk(32'(i_dev.range_now), 32'h5, "range from span register");
  endtask

  task t_read;
    run_op(OP_WRITE, 1'b0, 1'b0, 1'b0, 32'h0001_0001);
    run_op(OP_READ, 1'b0, 1'b0, 1'b0, 32'h0);
    apb(1'b0, OFS_RDAT, 32'h0);
    chk({14'h0, rd_v[17:0]}, 32'h10001, "input buffer readback");
    run_op(OP_READ, 1'b0, 1'b1, 1'b0, 32'h0);
    apb(1'b0, OFS_RDAT, 32'h0);
    chk({14'h0, rd_v[17:0]}, 32'h2a5c3, "dac buffer readback");
    chk(32'(i_dev.ddac_q), 32'h2a5c3, "no transfer during read");
    run_op(OP_READ, 1'b1, 1'b1, 1'b0, 32'h0);
    apb(1'b0, OFS_RDAT, 32'h0);
    chk({29'h0, rd_v[2:0]}, 32'h5, "span readback");
  endtask

  task t_busy;
    apb(1'b1, OFS_CTRL, 32'h1 | (32'(OP_UPDATE) << CTRL_OP_LSB));
    apb(1'b1, OFS_DATA, 32'h0000_0007);
    wait_done();
    apb(1'b0, OFS_DATA, 32'h0);
    chk(rd_v, 32'h0, "data write while busy ignored");
    chk(32'(i_dev.ddac_q), 32'h10001, "update after refused write");
    run_op(OP_NONE, 1'b0, 1'b0, 1'b0, 32'h0);
    chk(32'(i_dev.din_q), 32'h10001, "idle order writes nothing");
  endtask

  task t_fixed;
    run_op(OP_WRITE, 1'b1, 1'b0, 1'b1, 32'h0003_ffff);
    chk(32'(saw_fixed), 32'h1, "fixed range pin raised");
    chk(32'(fixed_bad), 32'h0, "select low, span pins free");
    chk(32'(i_dev.din_q), 32'h3ffff, "fixed mode data write");
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_i <= 1'b0;
    t_reset();
    t_write();
    t_update();
    t_read();
    t_busy();
    t_fixed();
    results();
  end
endmodule
